/* fsc_pkg.sv */
// Shared constants, status layout and instruction decode for the flash status register block.
`default_nettype none
package fsc_pkg;
  localparam int ADDR_W = 23;
  localparam int WRITE_CYCLES_DEF = 64;
  localparam int PROG_CYCLES_DEF = 128;
  localparam int ERASE_CYCLES_DEF = 1024;
  localparam logic [15:0] SR_FACTORY = 16'h0000;
  localparam logic [7:0] SR_LOW_WR_MASK = 8'hfc;
  localparam logic [7:0] SR_MID_WR_MASK = 8'h43;
  localparam logic [2:0] BP_NONE = 3'h0;
  localparam logic [2:0] BP_ALL = 3'h7;
  localparam logic [4:0] BLOCK_EXP = 5'h10;
  localparam logic [4:0] SECTOR_EXP = 5'h0c;
  localparam logic [7:0] OPC_WREN = 8'h06;
  localparam logic [7:0] OPC_WRDI = 8'h04;
  localparam logic [7:0] OPC_WRSR = 8'h01;
  localparam logic [7:0] OPC_WRSR2 = 8'h31;
  localparam logic [7:0] OPC_RDSR = 8'h05;
  localparam logic [7:0] OPC_RDSR2 = 8'h35;
  localparam logic [7:0] OPC_PP = 8'h02;
  localparam logic [7:0] OPC_QPP = 8'h32;
  localparam logic [7:0] OPC_SE = 8'h20;
  localparam logic [7:0] OPC_BE32 = 8'h52;
  localparam logic [7:0] OPC_BE64 = 8'hd8;
  localparam logic [7:0] OPC_CE1 = 8'hc7;
  localparam logic [7:0] OPC_CE2 = 8'h60;
  localparam logic [7:0] OPC_SECER = 8'h44;
  localparam logic [7:0] OPC_SECPR = 8'h42;
  localparam logic [7:0] OPC_SUSP = 8'h75;
  localparam logic [7:0] OPC_RESUME = 8'h7a;

  typedef struct packed {
    logic       paused_op_flag;
    logic       cmp;
    logic [2:0] lock_bits;
    logic       rsv;
    logic       qe;
    logic       status_lock_bit;
    logic       status_guard_mode;
    logic       sec;
    logic       tb;
    logic [2:0] bp;
    logic       write_enable_latch;
    logic       busy;
  } fsc_status_t;

  typedef enum logic [3:0] {
    K_NONE, K_WREN, K_WRDI, K_WRSR, K_WRSR2, K_READ, K_PROG,
    K_ERASE, K_CHIP, K_SECOP, K_SUSP, K_RESUME
  } fsc_kind_t;

  function automatic fsc_kind_t fsc_decode(input logic [7:0] opc);
    case (opc)
      OPC_WREN: return K_WREN;
      OPC_WRDI: return K_WRDI;
      OPC_WRSR: return K_WRSR;
      OPC_WRSR2: return K_WRSR2;
      OPC_RDSR, OPC_RDSR2: return K_READ;
      OPC_PP, OPC_QPP: return K_PROG;
      OPC_SE, OPC_BE32, OPC_BE64: return K_ERASE;
      OPC_CE1, OPC_CE2: return K_CHIP;
      OPC_SECER, OPC_SECPR: return K_SECOP;
      OPC_SUSP: return K_SUSP;
      OPC_RESUME: return K_RESUME;
      default: return K_NONE;
    endcase
  endfunction
endpackage
`default_nettype wire

/* fsc_sync.sv */
// Two-flop synchroniser for a group of independent level signals.
`timescale 1ns/10ps
`default_nettype none
module fsc_sync #(
  parameter int         W    = 1,
  parameter logic [W-1:0] INIT = '0
) (
  input  wire logic         clk_in,
  input  wire logic         nrst_in,
  input  wire logic [W-1:0] d_in,
  output logic      [W-1:0] q_out
);
  logic [W-1:0] meta;

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      meta  <= INIT;
      q_out <= INIT;
    end else begin
      meta  <= d_in;
      q_out <= meta;
    end
  end
endmodule // fsc_sync
`default_nettype wire

/* fsc_prot.sv */
// Array protection decode from range, side, granularity and complement settings.
`timescale 1ns/10ps
`default_nettype none
module fsc_prot
  import fsc_pkg::*;
#(
  parameter int AW = ADDR_W
) (
  input  wire logic [AW-1:0] addr_in,
  input  wire logic [2:0]    bp_in,
  input  wire logic          tb_in,
  input  wire logic          sec_in,
  input  wire logic          cmp_in,
  output logic               prot_out,
  output logic               any_prot_out
);
  logic [4:0] exp_lo;
  logic       in_rng;

  // Size of the range is 2**exp_lo bytes at the chosen end of the array.
  always_comb begin
    if (sec_in) begin
      exp_lo = SECTOR_EXP + ((bp_in >= 3'h4) ? 5'h3 : 5'({bp_in - 3'h1}));
    end else begin
      exp_lo = BLOCK_EXP + 5'(bp_in);
    end
    in_rng = (bp_in != BP_NONE);
    for (int i = 0; i < AW; i++) begin
      if (i >= int'(exp_lo) && bp_in != BP_ALL && addr_in[i] != !tb_in) begin
        in_rng = 1'b0;
      end
    end
    prot_out     = in_rng ^ cmp_in;
    any_prot_out = cmp_in ? (bp_in != BP_ALL) : (bp_in != BP_NONE);
  end
endmodule // fsc_prot
`default_nettype wire

/* fsc_regs.sv */
// Status and configuration registers of a serial flash, with the serial link front end.
`timescale 1ns/10ps
`default_nettype none
// Functional notes
// - Busy flag is 1 while program, erase, status write or security operation runs.
// - While busy, only status reads and suspend are honoured; others are dropped.
// - Busy clears when the running operation completes.
// - Write enable instruction sets write_enable_latch.
// - Latch clears at reset, write disable and every program, erase or status write.
// - Three protect_range_bits at bits 4..2, written by status write, default zero.
// - Program and erase into the protected area are rejected.
// - top_bottom_select 0 protects from the top, 1 from the bottom.
// - top_bottom_select changes only when guard mode, lock and latch allow it.
// - small_unit_select 1 means 4KB sectors, 0 means 64KB blocks.
// - invert_protection at bit 14 swaps protected and unprotected areas.
// - Guard mode 0 ignores the protect pin; writes need the latch set.
// - Guard mode 1 with protect pin low refuses all status writes while quad_enable is clear.
// - Guard mode 1 with protect pin high allows writes once latch is set.
// - Lock bit set by a status write blocks further writes until power cycle.
// - An otp lock can be entered by request, after which status writes fail until power cycle.
// - quad_enable set disables the protect pin entirely.
// - paused_op_flag at bit 15 sets on suspend, clears on resume or power cycle.
// - quad_enable is a stored read/write bit at bit 9.
module fsc_regs
  import fsc_pkg::*;
#(
  parameter int WRITE_CYCLES = WRITE_CYCLES_DEF,
  parameter int PROG_CYCLES  = PROG_CYCLES_DEF,
  parameter int ERASE_CYCLES = ERASE_CYCLES_DEF
) (
  input  wire logic              mclk_in,
  input  wire logic              nrst_in,
  input  wire logic              ce_in,
  input  wire logic              sclk_in,
  input  wire logic              cs_n_in,
  input  wire logic              mosi_in,
  input  wire logic              wp_n_in,
  input  wire logic              otp_lock_req_in,
  output logic                   miso_out,
  output logic                   miso_oe_n_out,
  output fsc_status_t            status_out,
  output logic                   array_op_out,
  output logic      [ADDR_W-1:0] array_addr_out
);
  typedef enum logic [1:0] {ST_LOAD, ST_IDLE, ST_BUSY, ST_SUSP} fsc_state_t;

  // Link side: shifts instruction bytes in and status bytes out on the host clock.
  logic [5:0]  bit_cnt;
  logic [7:0]  shift;
  logic [7:0]  frame_byte [0:3];
  logic [2:0]  nbytes;
  logic        rd_active;
  logic        rd_hi;
  logic [7:0]  out_byte;
  logic [15:0] st_link;
  logic [7:0]  rx_byte;
  logic        byte_done;
  logic        rd_sel;

  assign rx_byte   = {shift[6:0], mosi_in};
  assign byte_done = (bit_cnt[2:0] == 3'h7);
  assign rd_sel    = (bit_cnt[5:3] == 3'h0) ? (rx_byte == OPC_RDSR2) : rd_hi;

  // The host clock stops between frames, so the frame position is cleared by chip select.
  always_ff @(posedge sclk_in or posedge cs_n_in) begin
    if (cs_n_in) begin
      bit_cnt <= 6'h00;
    end else if (bit_cnt != 6'h3f) begin
      bit_cnt <= bit_cnt + 6'h01;
    end
  end

  // Captured bytes outlive the frame; the core reads them only after chip select rises.
  always_ff @(posedge sclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      shift  <= 8'h00;
      nbytes <= 3'h0;
      for (int i = 0; i < 4; i++) begin
        frame_byte[i] <= 8'h00;
      end
    end else begin
      shift <= rx_byte;
      if (byte_done && !bit_cnt[5]) begin
        frame_byte[bit_cnt[4:3]] <= rx_byte;
        nbytes                   <= {1'b0, bit_cnt[4:3]} + 3'h1;
      end else if (bit_cnt == 6'h00) begin
        nbytes <= 3'h0;
      end
    end
  end

  always_ff @(posedge sclk_in or posedge cs_n_in) begin
    if (cs_n_in) begin
      rd_active <= 1'b0;
      rd_hi     <= 1'b0;
      out_byte  <= 8'h00;
    end else if (byte_done) begin
      if (bit_cnt[5:3] == 3'h0) begin
        rd_active <= (fsc_decode(rx_byte) == K_READ);
        rd_hi     <= rd_sel;
      end
      out_byte <= rd_sel ? st_link[15:8] : st_link[7:0];
    end
  end

  always_ff @(negedge sclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      miso_out <= 1'b0;
    end else begin
      miso_out <= out_byte[3'h7 - bit_cnt[2:0]];
    end
  end

  assign miso_oe_n_out = !rd_active;

  // Each status bit is an independent level; the opcode byte flushes the chain first.
  fsc_sync #(.W(16), .INIT(SR_FACTORY)) u_st_sync (
    .clk_in  (sclk_in),
    .nrst_in (nrst_in),
    .d_in    (status_out),
    .q_out   (st_link)
  );

  // Core side.
  logic [1:0]  pins_s;
  logic        cs_d;
  logic        frame_end;
  logic        wp_n_s;
  fsc_state_t  state;
  logic [31:0] timer;
  logic        op_sr;
  fsc_status_t sr;
  fsc_status_t nv_sr;
  fsc_status_t pend_sr;
  logic        write_enable_latch;
  logic        paused_op_flag;
  logic        lock_vol;
  logic        otp;
  fsc_kind_t   kind;
  logic [ADDR_W-1:0] addr;
  logic        prot;
  logic        any_prot;
  logic        sr_ok;
  logic        arr_ok;
  logic        go;
  logic [31:0] next_timer;
  fsc_status_t next_sr;

  fsc_sync #(.W(2), .INIT(2'h3)) u_pin_sync (
    .clk_in  (mclk_in),
    .nrst_in (nrst_in),
    .d_in    ({cs_n_in, wp_n_in}),
    .q_out   (pins_s)
  );

  assign wp_n_s    = pins_s[0];
  assign frame_end = pins_s[1] && !cs_d;
  assign kind      = fsc_decode(frame_byte[0]);
  assign addr      = ADDR_W'({frame_byte[1], frame_byte[2], frame_byte[3]});
  assign go        = frame_end && ce_in;

  fsc_prot #(.AW(ADDR_W)) u_prot (
    .addr_in      (addr),
    .bp_in        (sr.bp),
    .tb_in        (sr.tb),
    .sec_in       (sr.sec),
    .cmp_in       (sr.cmp),
    .prot_out     (prot),
    .any_prot_out (any_prot)
  );

  always_comb begin
    // Guard mode and pin count only when quad mode has not taken the pin over.
    sr_ok = write_enable_latch && !lock_vol && !otp
            && !(sr.status_guard_mode && !sr.qe && !wp_n_s);
    arr_ok = write_enable_latch && (kind == K_CHIP ? !any_prot : (nbytes == 3'h4 && !prot));
    next_sr = sr;
    if (kind == K_WRSR2) begin
      next_sr[15:8] = (sr[15:8] & ~SR_MID_WR_MASK) | (frame_byte[1] & SR_MID_WR_MASK);
    end else begin
      next_sr[7:0] = (sr[7:0] & ~SR_LOW_WR_MASK) | (frame_byte[1] & SR_LOW_WR_MASK);
      if (nbytes == 3'h3) begin
        next_sr[15:8] = (sr[15:8] & ~SR_MID_WR_MASK) | (frame_byte[2] & SR_MID_WR_MASK);
      end
    end
    case (kind)
      K_WRSR, K_WRSR2: next_timer = WRITE_CYCLES;
      K_ERASE, K_CHIP: next_timer = ERASE_CYCLES;
      default: next_timer = PROG_CYCLES;
    endcase
  end

  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      cs_d <= 1'b1;
    end else if (ce_in) begin
      cs_d <= pins_s[1];
    end
  end

  // Operation sequencer: load, idle, running and suspended.
  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      state <= ST_LOAD;
      timer <= 32'h0;
      op_sr <= 1'b0;
    end else if (ce_in) begin
      case (state)
        ST_LOAD: state <= ST_IDLE;
        ST_IDLE: begin
          if (frame_end && ((kind inside {K_WRSR, K_WRSR2} && sr_ok && nbytes >= 3'h2)
              || (kind inside {K_PROG, K_ERASE, K_CHIP} && arr_ok)
              || (kind == K_SECOP && write_enable_latch))) begin
            state <= ST_BUSY;
            timer <= next_timer;
            op_sr <= kind inside {K_WRSR, K_WRSR2};
          end
        end
        ST_BUSY: begin
          if (timer <= 32'h1) begin
            state <= ST_IDLE;
            timer <= 32'h0;
          end else if (frame_end && kind == K_SUSP && !op_sr) begin
            state <= ST_SUSP;
          end else begin
            timer <= timer - 32'h1;
          end
        end
        ST_SUSP: begin
          if (frame_end && kind == K_RESUME) begin
            state <= ST_BUSY;
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // Write enable latch; ignored instructions while busy leave it alone.
  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      write_enable_latch <= 1'b0;
    end else if (go && state != ST_BUSY && state != ST_LOAD) begin
      if (kind == K_WREN) begin
        write_enable_latch <= 1'b1;
      end else if (kind inside {K_WRDI, K_WRSR, K_WRSR2, K_PROG, K_ERASE, K_CHIP, K_SECOP}) begin
        write_enable_latch <= 1'b0;
      end
    end
  end

  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      paused_op_flag <= 1'b0;
    end else if (go && state == ST_BUSY && kind == K_SUSP && !op_sr && timer > 32'h1) begin
      paused_op_flag <= 1'b1;
    end else if (go && state == ST_SUSP && kind == K_RESUME) begin
      paused_op_flag <= 1'b0;
    end
  end

  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      pend_sr <= SR_FACTORY;
    end else if (go && state == ST_IDLE && sr_ok) begin
      pend_sr <= next_sr;
    end
  end

  // The store models the stored bits; a reset here stands for a power cycle.
  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      sr       <= SR_FACTORY;
      nv_sr    <= SR_FACTORY;
      lock_vol <= 1'b0;
      otp      <= 1'b0;
    end else if (ce_in) begin
      if (state == ST_LOAD) begin
        sr <= nv_sr;
      end else if (state == ST_BUSY && op_sr && timer <= 32'h1) begin
        sr       <= pend_sr;
        nv_sr    <= pend_sr;
        lock_vol <= pend_sr.status_lock_bit;
      end
      if (otp_lock_req_in) begin
        otp <= 1'b1;
      end
    end
  end

  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      array_op_out   <= 1'b0;
      array_addr_out <= '0;
    end else if (ce_in) begin
      array_op_out <= frame_end && state == ST_IDLE
                      && kind inside {K_PROG, K_ERASE, K_CHIP} && arr_ok;
      if (frame_end) begin
        array_addr_out <= addr;
      end
    end
  end

  always_comb begin
    status_out           = sr;
    status_out.busy      = (state == ST_BUSY) || (state == ST_LOAD);
    status_out.write_enable_latch       = write_enable_latch;
    status_out.paused_op_flag       = paused_op_flag;
    status_out.status_lock_bit       = lock_vol || otp;
    status_out.lock_bits = 3'h0;
    status_out.rsv       = 1'b0;
  end

  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!nrst_in);

  AST_BUSY_SET: assert property (ce_in && state == ST_IDLE && frame_end
    && kind == K_SECOP && write_enable_latch |=> status_out.busy)
    else $error("busy not set on operation start");
  AST_BUSY_IGNORE: assert property (ce_in && state == ST_BUSY && frame_end
    && kind == K_WREN |=> write_enable_latch == $past(write_enable_latch))
    else $error("instruction honoured while busy");
  AST_BUSY_CLEAR: assert property (ce_in && state == ST_BUSY
    && timer == 32'h1 |=> !status_out.busy)
    else $error("busy not cleared at completion");
  AST_WEL_SET: assert property (ce_in && state == ST_IDLE && frame_end
    && kind == K_WREN |=> write_enable_latch ##1 write_enable_latch || !$stable(cs_d))
    else $error("latch not set");
  AST_WEL_CLR: assert property (ce_in && state == ST_IDLE && frame_end
    && kind inside {K_WRDI, K_PROG, K_ERASE} |=> !write_enable_latch)
    else $error("latch not cleared");
  AST_PROT_REJECT: assert property (ce_in && state == ST_IDLE && frame_end
    && kind == K_PROG && prot |=> !status_out.busy && !array_op_out)
    else $error("protected program accepted");
  AST_HW_GUARD: assert property (ce_in && state == ST_IDLE && frame_end
    && kind == K_WRSR && sr.status_guard_mode && !sr.qe && !wp_n_s |=> !status_out.busy)
    else $error("guard pin ignored");
  AST_NO_WEL: assert property (ce_in && state == ST_IDLE && frame_end
    && kind == K_WRSR && !write_enable_latch |=> state == ST_IDLE)
    else $error("status write without latch");
  AST_LOCKED: assert property (ce_in && state == ST_IDLE && frame_end
    && kind inside {K_WRSR, K_WRSR2} && (lock_vol || otp) |=> !status_out.busy)
    else $error("locked register written");
  AST_SUSPEND: assert property (ce_in && state == ST_BUSY && frame_end
    && kind == K_SUSP && !op_sr && timer > 32'h1
    |=> status_out.paused_op_flag && !status_out.busy ##1 status_out.paused_op_flag)
    else $error("suspend not reflected");
  AST_LOAD: assert property ($rose(nrst_in) |-> status_out.busy)
    else $error("instruction window open before load");

  COV_STATUS_WRITE: cover property (state == ST_BUSY && op_sr ##[1:1000] state == ST_IDLE);
  COV_SUSPEND_RESUME: cover property (state == ST_SUSP ##[1:1000] state == ST_BUSY);
  COV_PROT_HIT: cover property (frame_end && kind == K_ERASE && prot && write_enable_latch);
endmodule // fsc_regs
`default_nettype wire

/* fsc_host.sv */
// Behavioural serial host that frames instructions for the status register block.
`timescale 1ns/10ps
`default_nettype none
module fsc_host (
  output logic      sclk_out,
  output logic      cs_n_out,
  output logic      mosi_out,
  input  wire logic miso_in,
  input  wire logic miso_oe_n_in
);
  logic last_miso;
  logic miso_line;

  // A released data line has no defined level, so the host sees a toggling value there.
  assign miso_line = miso_oe_n_in ? ~last_miso : miso_in;

  initial begin
    sclk_out = 1'b0;
    cs_n_out = 1'b1;
    mosi_out = 1'b1;
    last_miso = 1'b0;
  end

  // The link clock runs only inside a frame and idles low; period 12 ns, MSB first.
  task automatic xfer(input int n, input logic [31:0] tx, output logic [31:0] rx);
    rx = '0;
    #3 cs_n_out = 1'b0;
    for (int i = 0; i < 8 * n; i++) begin
      mosi_out = tx[31 - i];
      #6 sclk_out = 1'b1;
      rx[31 - i] = miso_line;
      last_miso = miso_line;
      #6 sclk_out = 1'b0;
    end
    #6 cs_n_out = 1'b1;
    mosi_out = ~mosi_out;
  endtask
endmodule // fsc_host
`default_nettype wire

/* fsc_regs_test.sv */
// Self-checking testbench of the flash status register block against a behavioural model.
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin failures++; \
  $display("BAD t=%0t got=%h exp=%h", $time, a, b); end end
module fsc_regs_test;
  import fsc_pkg::*;
  localparam int WC = 32;
  localparam int PC = 32;
  localparam int EC = 96;
  logic              mclk, nrst, sclk, cs_n, mosi, wp_n, otp, miso, miso_oe_n, op, ce;
  fsc_status_t       st;
  logic [ADDR_W-1:0] addr;
  int                failures, n_compared, n_ops, cyc;
  logic [15:0]       m_sr, m_pend, v;
  logic [31:0]       rx;
  logic [15:0]       cfg [9] = '{16'h0000, 16'h0004, 16'h0004, 16'h0024, 16'h0024,
                                 16'h0044, 16'h0044, 16'h4004, 16'h4004};
  logic [23:0]       ad [9] = '{24'h7fffff, 24'h7e0000, 24'h7dffff, 24'h000000, 24'h7fffff,
                                24'h7ff000, 24'h7fe000, 24'h7fffff, 24'h000000};
  bit                pr [9] = '{0, 1, 0, 1, 0, 1, 0, 0, 1};

  fsc_host fsc_host_i (.sclk_out(sclk), .cs_n_out(cs_n), .mosi_out(mosi),
    .miso_in(miso), .miso_oe_n_in(miso_oe_n));
  fsc_regs #(.WRITE_CYCLES(WC), .PROG_CYCLES(PC), .ERASE_CYCLES(EC)) fsc_regs_i (
    .mclk_in(mclk), .nrst_in(nrst), .ce_in(ce), .sclk_in(sclk), .cs_n_in(cs_n),
    .mosi_in(mosi), .wp_n_in(wp_n), .otp_lock_req_in(otp), .miso_out(miso),
    .miso_oe_n_out(miso_oe_n), .status_out(st), .array_op_out(op), .array_addr_out(addr));

  initial mclk = 1'b0;
  always #20 mclk = ~mclk;

  always @(posedge mclk) begin
    if (op === 1'b1) n_ops++;
    cyc++;
    if (cyc == 20000) begin
      failures++;
      end_sim();
    end
  end

  task automatic end_sim();
    $display("compared=%0d failures=%0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic wt(input int n);
    repeat (n) @(negedge mclk);
  endtask

  // The idle gap after each frame also keeps chip select high long enough between frames.
  task automatic frame(input int n, input logic [31:0] tx);
    fsc_host_i.xfer(n, tx, rx);
    wt(8);
  endtask

  task automatic rst();
    nrst = 1'b0;
    wt(4);
    nrst = 1'b1;
    m_sr = '0;
    wt(4);
  endtask

  task automatic settle(input int n);
    wt(n);
    if (m_sr[0]) m_sr = m_pend;
  endtask

  task automatic wren();
    frame(1, {OPC_WREN, 24'h0});
    if (!m_sr[0]) m_sr[1] = 1'b1;
  endtask

  task automatic wrsr(input logic [15:0] d);
    frame(3, {OPC_WRSR, d[7:0], d[15:8], 8'h00});
    if (!m_sr[0]) begin
      if (m_sr[1] && !m_sr[8] && !(m_sr[7] && !m_sr[9] && !wp_n)) begin
        m_pend = (m_sr & ~16'h43fe) | (d & 16'h43fc);
        m_sr[0] = 1'b1;
      end
      m_sr[1] = 1'b0;
    end
  endtask

  task automatic cfg_wr(input logic [15:0] d);
    wren();
    wrsr(d);
    settle(WC + 8);
    `CHK(st, m_sr)
  endtask

  task automatic arr(input logic [7:0] opc, input logic [23:0] a, input bit prot);
    int k;
    k = n_ops;
    frame(4, {opc, a});
    m_sr[1] = 1'b0;
    if (!prot) begin
      m_pend = m_sr;
      m_sr[0] = 1'b1;
      `CHK(addr, a[22:0])
    end
    `CHK(n_ops, k + (prot ? 0 : 1))
    `CHK(st, m_sr)
  endtask

  task automatic rd(input logic [7:0] opc, input logic [7:0] exp_b);
    frame(2, {opc, 24'h0});
    `CHK(rx[23:16], exp_b)
    `CHK(miso_oe_n, 1'b1)
  endtask

  initial begin
    failures = 0;
    n_compared = 0;
    n_ops = 0;
    cyc = 0;
    nrst = 1'b0;
    wp_n = 1'b1;
    otp = 1'b0;
    ce = 1'b1;
    m_pend = '0;
    void'($urandom(32'h627a));
    rst();
    `CHK(st, m_sr)
    wren();
    `CHK(st, m_sr)
    frame(1, {OPC_WRDI, 24'h0});
    m_sr[1] = 1'b0;
    `CHK(st, m_sr)
    wrsr(16'h001c);
    `CHK(st, m_sr)
    $display("test latch done");
    for (int i = 0; i < 4; i++) begin
      v = 16'($urandom) & 16'hfeff;
      wren();
      wrsr(v);
      `CHK(st, m_sr)
      wren();
      `CHK(st, m_sr)
      settle(WC + 8);
      `CHK(st, m_sr)
      rd(OPC_RDSR, m_sr[7:0]);
      rd(OPC_RDSR2, m_sr[15:8]);
    end
    $display("test random status writes done");
    for (int i = 0; i < 9; i++) begin
      cfg_wr(cfg[i]);
      wren();
      arr(OPC_PP, ad[i], pr[i]);
      settle(PC + 8);
    end
    cfg_wr(16'h001c);
    wren();
    arr(OPC_QPP, 24'h000000, 1'b1);
    wren();
    arr(OPC_CE1, 24'h000000, 1'b1);
    $display("test protection done");
    cfg_wr(16'h0000);
    wren();
    arr(OPC_SE, 24'h001000, 1'b0);
    frame(1, {OPC_SUSP, 24'h0});
    m_sr[15] = 1'b1;
    m_sr[0] = 1'b0;
    `CHK(st, m_sr)
    frame(1, {OPC_RESUME, 24'h0});
    m_sr[15] = 1'b0;
    m_sr[0] = 1'b1;
    `CHK(st, m_sr)
    settle(EC + 8);
    `CHK(st, m_sr)
    wren();
    frame(1, {OPC_SECER, 24'h0});
    m_sr[1] = 1'b0;
    m_pend = m_sr;
    m_sr[0] = 1'b1;
    `CHK(st, m_sr)
    settle(PC + 8);
    `CHK(st, m_sr)
    $display("test suspend done");
    cfg_wr(16'h0080);
    wp_n = 1'b0;
    wt(4);
    wren();
    wrsr(16'h0084);
    `CHK(st, m_sr)
    wp_n = 1'b1;
    wt(4);
    wren();
    wrsr(16'h0284);
    `CHK(st, m_sr)
    ce = 1'b0;
    wt(WC + 8);
    `CHK(st, m_sr)
    ce = 1'b1;
    settle(WC + 8);
    wp_n = 1'b0;
    wt(4);
    wren();
    wrsr(16'h0280);
    `CHK(st, m_sr)
    settle(WC + 8);
    $display("test guard done");
    cfg_wr(16'h0100);
    `CHK(st, m_sr)
    wren();
    wrsr(16'h0000);
    `CHK(st, m_sr)
    wren();
    frame(2, {OPC_WRSR2, 8'h02, 16'h0});
    m_sr[1] = 1'b0;
    `CHK(st, m_sr)
    rst();
    `CHK(st, m_sr)
    otp = 1'b1;
    wt(2);
    otp = 1'b0;
    m_sr[8] = 1'b1;
    wren();
    wrsr(16'h0000);
    `CHK(st, m_sr)
    $display("test locks done");
    end_sim();
  end
endmodule // fsc_regs_test
`default_nettype wire
